// [rtl/sau_pkg.sv]
// Purpose: shared constants, operation codes and argument checks for the saturating arithmetic unit
// Assumes: 32-bit data path, register indices of four bits
// Notes:   both ends use sau_args_ok so that they agree on what is legal
package sau_pkg;
	localparam int DATA_W = 32;
	localparam int HALF_W = 16;
	localparam int BYTE_W = 8;
	localparam int N_W    = 6;
	localparam int SH_W   = 5;
	localparam int IDX_W  = 4;
	localparam int Q_BIT  = 27;

	localparam logic [N_W-1:0]   WORD_N       = 6'h20;
	localparam logic [N_W-1:0]   HALF_N       = 6'h10;
	localparam logic [N_W-1:0]   BYTE_N       = 6'h08;
	localparam logic [N_W-1:0]   SCLAMP_N_MIN = 6'h01;
	localparam logic [N_W-1:0]   SCLAMP_N_MAX = 6'h20;
	localparam logic [N_W-1:0]   UCLAMP_N_MAX = 6'h1F;
	localparam logic [N_W-1:0]   DSCLAMP_N_MAX = 6'h10;
	localparam logic [N_W-1:0]   DUCLAMP_N_MAX = 6'h0F;
	localparam logic [SH_W-1:0]  ASR_MIN      = 5'h01;
	localparam logic [IDX_W-1:0] STACK_POINTER_REG   = 4'hD;
	localparam logic [IDX_W-1:0] PROGRAM_COUNTER_REG = 4'hF;

	typedef enum logic [3:0] {
		OP_SIGNED_CLAMP        = 4'h0,
		OP_UNSIGNED_CLAMP      = 4'h1,
		OP_DUAL_SIGNED_CLAMP   = 4'h2,
		OP_DUAL_UNSIGNED_CLAMP = 4'h3,
		OP_SAT_ADD_WORD        = 4'h4,
		OP_SAT_SUB_WORD        = 4'h5,
		OP_SAT_ADD_BYTES       = 4'h6,
		OP_SAT_SUB_BYTES       = 4'h7,
		OP_SAT_ADD_HALVES      = 4'h8,
		OP_SAT_SUB_HALVES      = 4'h9,
		OP_SAT_ADD_SUB_EXCHANGE = 4'hA,
		OP_SAT_SUB_ADD_EXCHANGE = 4'hB,
		OP_STATUS_WRITE        = 4'hC,
		OP_STATUS_READ         = 4'hD
	} sau_op_t;

	// width and pre-shift ranges; status ops always fail, other ops without these fields are always legal
	function automatic logic sau_args_ok(input sau_op_t op, input logic [N_W-1:0] n,
		input logic arith_right_shift, input logic [SH_W-1:0] amt);
		logic sh_ok;
		sh_ok = !arith_right_shift || (amt >= ASR_MIN);
		case (op)
			OP_SIGNED_CLAMP:        sau_args_ok = sh_ok && (n >= SCLAMP_N_MIN) && (n <= SCLAMP_N_MAX);
			OP_UNSIGNED_CLAMP:      sau_args_ok = sh_ok && (n <= UCLAMP_N_MAX);
			OP_DUAL_SIGNED_CLAMP:   sau_args_ok = (n >= SCLAMP_N_MIN) && (n <= DSCLAMP_N_MAX);
			OP_DUAL_UNSIGNED_CLAMP: sau_args_ok = (n <= DUCLAMP_N_MAX);
			OP_STATUS_WRITE,
			OP_STATUS_READ:         sau_args_ok = 1'b0;
			default:                sau_args_ok = 1'b1;
		endcase
	endfunction
endpackage

// [rtl/sau_if.sv]
// Purpose: link between the issuing logic and the saturating arithmetic unit
// Assumes: both ends on sys_clk
// Notes:   op_valid is a one-cycle request, done the one-cycle answer
`timescale 1ns/1ps
interface sau_if;
	import sau_pkg::*;
	logic                   op_valid;
	sau_op_t                op_code;
	logic                   cond_pass;
	logic [N_W-1:0]         clamp_n;
	logic                   shift_asr;
	logic [SH_W-1:0]        shift_amt;
	logic [DATA_W-1:0]      operand_a;
	logic [DATA_W-1:0]      operand_b;
	logic                   status_clr;
	logic                   done;
	logic                   res_we;
	logic [DATA_W-1:0]      result;
	logic                   q_flag;

	modport dev (input op_valid, op_code, cond_pass, clamp_n, shift_asr, shift_amt, operand_a, operand_b,
		status_clr, output done, res_we, result, q_flag);
	modport host (output op_valid, op_code, cond_pass, clamp_n, shift_asr, shift_amt, operand_a, operand_b,
		status_clr, input done, res_we, result, q_flag);
endinterface // sau_if

// [rtl/sau_clamp.sv]
// Purpose: clamp a signed value to a signed or unsigned n-bit range
// Assumes: n within the range the caller allows
// Notes:   two guard bits keep 2^n positive for n equal to the input width
`timescale 1ns/1ps
module sau_clamp #(
	parameter int IN_W  = 33,
	parameter int OUT_W = 32,
	parameter int N_W   = 6
) (
	input  wire logic [IN_W-1:0]  value,
	input  wire logic [N_W-1:0]   width_n,
	input  wire logic             to_unsigned,
	output logic      [OUT_W-1:0] clamped,
	output logic                  saturated
);
	localparam int CW = IN_W + 2;
	localparam logic signed [CW-1:0] ONE = 1;

	logic signed [CW-1:0] v;
	logic signed [CW-1:0] pw;
	logic signed [CW-1:0] half_pw;
	logic signed [CW-1:0] hi_lim;
	logic signed [CW-1:0] lo_lim;
	logic                 over;
	logic                 under;

	assign v       = {{2{value[IN_W-1]}}, value};
	assign pw      = ONE << width_n;
	assign half_pw = pw >> 1;
	assign hi_lim  = to_unsigned ? pw - ONE : half_pw - ONE;
	assign lo_lim  = to_unsigned ? '0 : -half_pw;
	assign over    = v > hi_lim;
	assign under   = v < lo_lim;
	assign clamped   = over ? hi_lim[OUT_W-1:0] : (under ? lo_lim[OUT_W-1:0] : v[OUT_W-1:0]);
	assign saturated = over | under;
endmodule // sau_clamp

// [rtl/sau_unit.sv]
// Purpose: saturating arithmetic unit: clamps, lane add/sub and the sticky saturation flag
// Assumes: one request per op_valid pulse; answer one cycle later
// Notes:   no condition flag outputs exist, so those flags cannot be touched here
// Summary of operation
// RULE1 - signed clamp returns limits or input unchanged
// RULE2 - unsigned clamp returns zero, upper limit, or input
// RULE3 - saturation sets sticky flag, else it holds
// RULE4 - only an explicit status write clears flag
// RULE5 - sticky flag readable by status read
// RULE6 - signed clamp width 1 through 32
// RULE7 - unsigned clamp width 0 through 31
// RULE8 - pre-shift applied before saturation
// RULE9 - arithmetic right shift amount 1 to 31
// RULE10 - logical left shift amount 0 to 31
// RULE11 - unsigned clamp reads source as signed
// RULE12 - dual signed clamp width 1 through 16
// RULE13 - dual unsigned clamp width 0 through 15
// RULE14 - dual signed clamp halves saturate independently
// RULE15 - dual unsigned clamp halves saturate independently
// RULE16 - add/sub clamps to lane signed range
// RULE17 - four byte lanes or two halfword lanes
// RULE18 - byte and halfword lane forms leave flag
// RULE19 - condition flags never modified
// RULE20 - issuer never names stack pointer, program counter
// RULE21 - predicate gates compute, write, flag update; status read and write ignore req_cond
// RULE22 - exchange forms cross halves, saturate to 16
// RULE23 - registered flag; clear beats same-cycle set
`timescale 1ns/1ps
module sau_unit
	import sau_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rst,
	sau_if.dev        sau,
	output logic      sat_event,
	output logic      q_status
);
	logic                  exec;
	logic                  args_ok;
	logic                  is_sclamp;
	logic                  is_uclamp;
	logic                  is_single;
	logic                  is_dual;
	logic                  is_word_arith;
	logic                  is_asx;
	logic                  is_sax;
	logic                  is_sub_h;
	logic                  is_sub_b;
	logic [DATA_W-1:0]     shifted;
	logic [DATA_W:0]       w_in;
	logic [N_W-1:0]        w_n;
	logic [DATA_W-1:0]     w_res;
	logic                  w_sat;
	logic [DATA_W-1:0]     h_res;
	logic [1:0]            h_sat;
	logic [DATA_W-1:0]     b_res;
	logic                  set_q;
	logic [DATA_W-1:0]     next_result;
	logic                  q;
	logic                  done;
	logic                  res_we;
	logic [DATA_W-1:0]     result;
	logic                  sat_pulse;

	assign args_ok   = sau_args_ok(sau.op_code, sau.clamp_n, sau.shift_asr, sau.shift_amt); // RULE6 RULE7 RULE9 RULE10 RULE12 RULE13
	// out-of-range requests are answered but not executed
	assign exec      = sau.op_valid && sau.cond_pass && args_ok; // RULE21

	assign is_sclamp     = sau.op_code == OP_SIGNED_CLAMP;
	assign is_uclamp     = sau.op_code == OP_UNSIGNED_CLAMP;
	assign is_single     = is_sclamp || is_uclamp;
	assign is_dual       = (sau.op_code == OP_DUAL_SIGNED_CLAMP) || (sau.op_code == OP_DUAL_UNSIGNED_CLAMP);
	assign is_word_arith = (sau.op_code == OP_SAT_ADD_WORD) || (sau.op_code == OP_SAT_SUB_WORD);
	assign is_asx        = sau.op_code == OP_SAT_ADD_SUB_EXCHANGE;
	assign is_sax        = sau.op_code == OP_SAT_SUB_ADD_EXCHANGE;
	assign is_sub_h      = sau.op_code == OP_SAT_SUB_HALVES;
	assign is_sub_b      = sau.op_code == OP_SAT_SUB_BYTES;

	// shift first, saturate afterwards; left shift drops bits above bit 31
	assign shifted = sau.shift_asr ? DATA_W'($signed(sau.operand_b) >>> sau.shift_amt)
		: DATA_W'(sau.operand_b << sau.shift_amt); // RULE8

	// the unsigned clamp sign-extends too, so negative sources go to zero
	assign w_in = is_single ? {shifted[DATA_W-1], shifted} // RULE11
		: (sau.op_code == OP_SAT_SUB_WORD)
			? {sau.operand_a[DATA_W-1], sau.operand_a} - {sau.operand_b[DATA_W-1], sau.operand_b}
			: {sau.operand_a[DATA_W-1], sau.operand_a} + {sau.operand_b[DATA_W-1], sau.operand_b}; // RULE16
	assign w_n  = is_single ? sau.clamp_n : WORD_N;

	sau_clamp #(
		.IN_W  (DATA_W + 1),
		.OUT_W (DATA_W),
		.N_W   (N_W)
	) u_word_clamp (
		.value       (w_in),
		.width_n     (w_n),
		.to_unsigned (is_uclamp),
		.clamped     (w_res),
		.saturated   (w_sat)
	); // RULE1 RULE2

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_half
			localparam bit IS_LOW = (gi == 0);
			logic [HALF_W-1:0] own_a;
			logic [HALF_W-1:0] own_b;
			logic [HALF_W-1:0] cross_b;
			logic [HALF_W-1:0] rhs;
			logic              do_sub;
			logic [HALF_W:0]   lane_in;
			logic [N_W-1:0]    lane_n;

			assign own_a   = sau.operand_a[gi*HALF_W +: HALF_W];
			assign own_b   = sau.operand_b[gi*HALF_W +: HALF_W];
			assign cross_b = sau.operand_b[(1-gi)*HALF_W +: HALF_W];
			// exchange forms pair each half of a with the opposite half of b
			assign rhs     = (is_asx || is_sax) ? cross_b : own_b; // RULE22
			assign do_sub  = is_sub_h || (is_asx && IS_LOW) || (is_sax && !IS_LOW); // RULE22
			assign lane_in = is_dual ? {own_b[HALF_W-1], own_b} // RULE14 RULE15
				: do_sub ? {own_a[HALF_W-1], own_a} - {rhs[HALF_W-1], rhs}
				: {own_a[HALF_W-1], own_a} + {rhs[HALF_W-1], rhs}; // RULE17
			assign lane_n  = is_dual ? sau.clamp_n : HALF_N;

			sau_clamp #(
				.IN_W  (HALF_W + 1),
				.OUT_W (HALF_W),
				.N_W   (N_W)
			) u_half_clamp (
				.value       (lane_in),
				.width_n     (lane_n),
				.to_unsigned (sau.op_code == OP_DUAL_UNSIGNED_CLAMP),
				.clamped     (h_res[gi*HALF_W +: HALF_W]),
				.saturated   (h_sat[gi])
			); // RULE14 RULE15 RULE16
		end

		for (gi = 0; gi < 4; gi++) begin : g_byte
			logic [BYTE_W-1:0] ba;
			logic [BYTE_W-1:0] bb;
			logic [BYTE_W:0]   lane_in;

			assign ba      = sau.operand_a[gi*BYTE_W +: BYTE_W];
			assign bb      = sau.operand_b[gi*BYTE_W +: BYTE_W];
			assign lane_in = is_sub_b ? {ba[BYTE_W-1], ba} - {bb[BYTE_W-1], bb}
				: {ba[BYTE_W-1], ba} + {bb[BYTE_W-1], bb}; // RULE17

			sau_clamp #(
				.IN_W  (BYTE_W + 1),
				.OUT_W (BYTE_W),
				.N_W   (N_W)
			) u_byte_clamp (
				.value       (lane_in),
				.width_n     (BYTE_N),
				.to_unsigned (1'b0),
				.clamped     (b_res[gi*BYTE_W +: BYTE_W]),
				.saturated   ()
			); // RULE16
		end
	endgenerate

	always_comb begin
		case (sau.op_code)
			OP_SIGNED_CLAMP,
			OP_UNSIGNED_CLAMP,
			OP_SAT_ADD_WORD,
			OP_SAT_SUB_WORD:         next_result = w_res;
			OP_DUAL_SIGNED_CLAMP,
			OP_DUAL_UNSIGNED_CLAMP,
			OP_SAT_ADD_HALVES,
			OP_SAT_SUB_HALVES,
			OP_SAT_ADD_SUB_EXCHANGE,
			OP_SAT_SUB_ADD_EXCHANGE: next_result = h_res;
			OP_SAT_ADD_BYTES,
			OP_SAT_SUB_BYTES:        next_result = b_res;
			default:                 next_result = '0;
		endcase
	end

	// lane add/sub and exchange forms never feed the flag; their lane
	// saturations are deliberately ignored here
	assign set_q = exec && (((is_single || is_word_arith) && w_sat) || (is_dual && (|h_sat))); // RULE3 RULE18

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			q <= 1'b0;
		end else if (sau.status_clr) begin
			q <= 1'b0; // RULE4 RULE23
		end else if (set_q) begin
			q <= 1'b1; // RULE3
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			done      <= 1'b0;
			res_we    <= 1'b0;
			result    <= '0;
			sat_pulse <= 1'b0;
		end else begin
			done      <= sau.op_valid;
			res_we    <= exec; // RULE21
			sat_pulse <= set_q;
			if (exec) begin
				result <= next_result;
			end
		end
	end

	assign sau.done   = done;
	assign sau.res_we = res_we;
	assign sau.result = result; // RULE19
	assign sau.q_flag = q; // RULE5 RULE23
	assign sat_event  = sat_pulse;
	assign q_status   = q;
endmodule // sau_unit

// [rtl/sau_issuer.sv]
// Purpose: issuing side of the saturating unit: small register file, checks and write-back
// Assumes: user holds a request until req_ready; one request in flight
// Notes:   refused requests never reach the unit, so it sees only legal register names
`timescale 1ns/1ps
module sau_issuer
	import sau_pkg::*;
#(
	parameter int REG_COUNT = 16
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	sau_if.host                    sau,
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire sau_op_t           req_op,
	input  wire logic [IDX_W-1:0]  req_dst,
	input  wire logic [IDX_W-1:0]  req_src_a,
	input  wire logic [IDX_W-1:0]  req_src_b,
	input  wire logic              req_cond,
	input  wire logic [N_W-1:0]    req_n,
	input  wire logic              req_asr,
	input  wire logic [SH_W-1:0]   req_shamt,
	output logic                   req_refused,
	output logic                   req_done,
	input  wire logic              rf_wr_en,
	input  wire logic [IDX_W-1:0]  rf_wr_idx,
	input  wire logic [DATA_W-1:0] rf_wr_data,
	input  wire logic [IDX_W-1:0]  rf_rd_idx,
	output logic [DATA_W-1:0]      rf_rd_data
);
	typedef enum logic [1:0] {
		SAUH_IDLE = 2'b01,
		SAUH_WAIT = 2'b10
	} sauh_state_t;

	sauh_state_t       state;
	sauh_state_t       next_state;
	logic [DATA_W-1:0] rf [REG_COUNT];
	logic              accept;
	logic              bad_reg;
	logic              refuse;
	logic              is_status;
	logic              wb_en;
	logic [IDX_W-1:0]  wb_idx;
	logic [DATA_W-1:0] wb_data;
	logic [IDX_W-1:0]  dst;
	logic              op_valid;
	logic              status_clr;
	logic              refused;
	logic              done_out;

	assign req_ready = state == SAUH_IDLE;
	assign accept    = req_valid && req_ready;
	assign is_status = (req_op == OP_STATUS_WRITE) || (req_op == OP_STATUS_READ);
	// stack pointer and program counter are never sent to the unit
	assign bad_reg   = (req_dst == STACK_POINTER_REG) || (req_dst == PROGRAM_COUNTER_REG)
		|| (req_src_b == STACK_POINTER_REG) || (req_src_b == PROGRAM_COUNTER_REG)
		|| (req_src_a == STACK_POINTER_REG) || (req_src_a == PROGRAM_COUNTER_REG); // RULE20
	assign refuse    = bad_reg || (!is_status && !sau_args_ok(req_op, req_n, req_asr, req_shamt)); // RULE6 RULE9 RULE12

	assign wb_en   = (state == SAUH_WAIT && sau.done && sau.res_we) || (accept && !refuse && req_op == OP_STATUS_READ);
	assign wb_idx  = (state == SAUH_WAIT) ? dst : req_dst;
	assign wb_data = (state == SAUH_WAIT) ? sau.result : (DATA_W'(sau.q_flag) << Q_BIT); // RULE5

	always_comb begin
		case (state)
			SAUH_IDLE: next_state = (accept && !refuse && !is_status) ? SAUH_WAIT : SAUH_IDLE;
			SAUH_WAIT: next_state = sau.done ? SAUH_IDLE : SAUH_WAIT;
			default:   next_state = SAUH_IDLE;
		endcase
	end

	// unit results win over a same-cycle load from the user port
	always_ff @(posedge sys_clk) begin
		if (rf_wr_en) begin
			rf[rf_wr_idx] <= rf_wr_data;
		end
		if (wb_en) begin
			rf[wb_idx] <= wb_data;
		end
		rf_rd_data <= rf[rf_rd_idx];
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state         <= SAUH_IDLE;
			op_valid      <= 1'b0;
			status_clr    <= 1'b0;
			refused       <= 1'b0;
			done_out      <= 1'b0;
			dst           <= '0;
			sau.op_code   <= OP_SIGNED_CLAMP;
			sau.cond_pass <= 1'b0;
			sau.clamp_n   <= '0;
			sau.shift_asr <= 1'b0;
			sau.shift_amt <= '0;
			sau.operand_a <= '0;
			sau.operand_b <= '0;
		end else begin
			state      <= next_state;
			op_valid   <= accept && !refuse && !is_status;
			// writing a zero into the flag position is the only way to clear it
			status_clr <= accept && !refuse && req_op == OP_STATUS_WRITE && !rf[req_src_b][Q_BIT]; // RULE4
			refused    <= accept && refuse;
			done_out   <= (state == SAUH_WAIT && sau.done) || (accept && !refuse && is_status);
			if (accept) begin
				dst           <= req_dst;
				sau.op_code   <= req_op;
				sau.cond_pass <= req_cond; // RULE21
				sau.clamp_n   <= req_n;
				sau.shift_asr <= req_asr;
				sau.shift_amt <= req_shamt;
				sau.operand_a <= rf[req_src_a];
				sau.operand_b <= rf[req_src_b];
			end
		end
	end

	assign sau.op_valid   = op_valid;
	assign sau.status_clr = status_clr;
	assign req_refused    = refused;
	assign req_done       = done_out;
endmodule // sau_issuer

// [dv/sau_properties.sv]
// Purpose: concurrent checks on the issuer-unit link
// Assumes: one clock, rst active high
// Notes:   the word-add check keeps its own clamp
`timescale 1ns/1ps
module sau_properties
	import sau_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              rst,
	input wire logic              op_valid,
	input wire sau_op_t           op_code,
	input wire logic              cond_pass,
	input wire logic [N_W-1:0]    clamp_n,
	input wire logic              shift_asr,
	input wire logic [SH_W-1:0]   shift_amt,
	input wire logic [DATA_W-1:0] operand_a,
	input wire logic [DATA_W-1:0] operand_b,
	input wire logic              status_clr,
	input wire logic              done,
	input wire logic              res_we,
	input wire logic [DATA_W-1:0] result,
	input wire logic              q_flag
);
	wire logic [DATA_W:0]   sum_ext = {operand_a[31], operand_a} + {operand_b[31], operand_b};
	wire logic              sum_ovf = sum_ext[32] ^ sum_ext[31];
	wire logic [DATA_W-1:0] sum_sat = sum_ovf ? (sum_ext[32] ? 32'h8000_0000 : 32'h7FFF_FFFF) : sum_ext[31:0];
	wire logic              single = op_code <= OP_UNSIGNED_CLAMP;
	wire logic              lane_op = (op_code >= OP_SAT_ADD_BYTES) && (op_code <= OP_SAT_SUB_ADD_EXCHANGE);

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_done_follows_op: assert property (op_valid |=> done)
		else $error("no answer after a request");
	a_pred_blocks_write: assert property (op_valid && !cond_pass |=> !res_we && $stable(result))
		else $error("failed predicate wrote a result");
	a_word_add_sat: assert property (op_valid && cond_pass && op_code == OP_SAT_ADD_WORD && !status_clr |=>
		res_we && result == $past(sum_sat) && q_flag == ($past(q_flag) | $past(sum_ovf)))
		else $error("word add result or flag wrong");
	a_clear_wins: assert property (status_clr |=> !q_flag)
		else $error("clear strobe ignored");
	a_flag_sticky: assert property (q_flag && !status_clr |=> q_flag)
		else $error("flag dropped without a clear");
	a_lane_flag_hold: assert property (op_valid && lane_op && !status_clr |=> $stable(q_flag))
		else $error("lane form changed the flag");
	a_sclamp_width: assert property (op_valid && op_code == OP_SIGNED_CLAMP |-> clamp_n >= 6'h01 && clamp_n <= 6'h20)
		else $error("signed clamp width out of range");
	a_asr_amount: assert property (op_valid && single && shift_asr |-> shift_amt != 5'h00)
		else $error("arithmetic shift by zero issued");
	a_uclamp_range: assert property (op_valid && cond_pass && op_code == OP_UNSIGNED_CLAMP |=>
		(result >> $past(clamp_n)) == 32'h0)
		else $error("unsigned clamp above its range");

	c_word_ovf: cover property (op_valid && op_code == OP_SAT_ADD_WORD && sum_ovf);
	c_clear_set: cover property (status_clr && q_flag);
	c_pred_fail: cover property (op_valid && !cond_pass);
endmodule // sau_properties

// [dv/saturating_arith_unit_tb.sv]
// Purpose: self-checking bench for issuer and unit
// Assumes: arithmetic answers two edges after take, other ops at once
// Notes:   expectations come from the model below
`timescale 1ns/1ps
module saturating_arith_unit_tb;
	import sau_pkg::*;
	localparam logic [31:0] MARK = 32'hA5A5_0F0F;
	logic              sys_clk;
	logic              rst;
	logic              req_valid;
	logic              req_ready;
	sau_op_t           req_op;
	logic [IDX_W-1:0]  req_dst;
	logic [IDX_W-1:0]  req_src_a;
	logic [IDX_W-1:0]  req_src_b;
	logic              req_cond;
	logic [N_W-1:0]    req_n;
	logic              req_asr;
	logic [SH_W-1:0]   req_shamt;
	logic              req_refused;
	logic              req_done;
	logic              rf_wr_en;
	logic [IDX_W-1:0]  rf_wr_idx;
	logic [DATA_W-1:0] rf_wr_data;
	logic [IDX_W-1:0]  rf_rd_idx;
	logic [DATA_W-1:0] rf_rd_data;
	logic              q_status;
	logic              expq;
	logic              sat_hit;
	logic              sat_ev;
	int                fails;
	int                checks_done;
	int                cycles;
	int                sat_count;
	int                i;

	sau_if link();
	sau_unit sau_unit_inst (.sys_clk, .rst, .sau(link), .sat_event(sat_ev), .q_status);
	sau_issuer sau_issuer_inst (.sys_clk, .rst, .sau(link), .req_valid, .req_ready, .req_op, .req_dst,
		.req_src_a, .req_src_b, .req_cond, .req_n, .req_asr, .req_shamt, .req_refused, .req_done,
		.rf_wr_en, .rf_wr_idx, .rf_wr_data, .rf_rd_idx, .rf_rd_data);
	sau_properties sau_properties_inst (.sys_clk(sys_clk), .rst(rst), .op_valid(link.op_valid),
		.op_code(link.op_code), .cond_pass(link.cond_pass), .clamp_n(link.clamp_n),
		.shift_asr(link.shift_asr), .shift_amt(link.shift_amt), .operand_a(link.operand_a),
		.operand_b(link.operand_b), .status_clr(link.status_clr), .done(link.done),
		.res_we(link.res_we), .result(link.result), .q_flag(link.q_flag));

	always #25 sys_clk = ~sys_clk;

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ceiling is a few times the expected run length
	always @(posedge sys_clk) begin
		cycles++;
		sat_count += sat_ev;
		if (cycles == 8000) begin
			fails++;
			final_report;
		end
	end

	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string what);
		chk_data({31'h0, got}, {31'h0, exp}, what);
	endtask

	function automatic longint cl(longint v, int n, bit u);
		longint hi;
		longint lo;
		hi = (longint'(1) << (u ? n : n - 1)) - 1;
		lo = u ? 0 : -hi - 1;
		if (v > hi || v < lo)
			sat_hit = 1'b1;
		cl = (v > hi) ? hi : ((v < lo) ? lo : v);
	endfunction

	// low w bits of x as a signed lane value
	function automatic longint sx(logic [31:0] x, int w);
		longint m;
		m = longint'(1) << w;
		sx = longint'(x) & (m - 1);
		if (sx >= m / 2)
			sx = sx - m;
	endfunction

	function automatic logic [31:0] model(sau_op_t op, logic [31:0] a, logic [31:0] b, int n, bit arith_right_shift, int sh);
		longint r;
		longint s;
		int w;
		r = 0;
		sat_hit = 1'b0;
		w = (op <= OP_SAT_SUB_WORD) ? 32 : ((op <= OP_SAT_SUB_BYTES) ? 8 : 16);
		// odd add/sub codes subtract
		s = op[0] ? -1 : 1;
		case (op)
			OP_SIGNED_CLAMP, OP_UNSIGNED_CLAMP:
				r = cl(arith_right_shift ? (sx(b, 32) >>> sh) : sx(b << sh, 32), n, op == OP_UNSIGNED_CLAMP);
			OP_DUAL_SIGNED_CLAMP, OP_DUAL_UNSIGNED_CLAMP:
				for (int k = 0; k < 2; k++)
					r = r | ((cl(sx(b >> (16 * k), 16), n, op == OP_DUAL_UNSIGNED_CLAMP) & 64'hFFFF) << (16 * k));
			OP_SAT_ADD_SUB_EXCHANGE, OP_SAT_SUB_ADD_EXCHANGE: begin
				r = (cl(sx(a >> 16, 16) + s * sx(b, 16), 16, 0) & 64'hFFFF) << 16;
				r = r | (cl(sx(a, 16) - s * sx(b >> 16, 16), 16, 0) & 64'hFFFF);
			end
			default:
				for (int k = 0; k < 32 / w; k++)
					r = r | ((cl(sx(a >> (w * k), w) + s * sx(b >> (w * k), w), w, 0)
						& ((longint'(1) << w) - 1)) << (w * k));
		endcase
		model = r[31:0];
	endfunction

	task automatic rf_load(input logic [3:0] idx, input logic [31:0] d);
		@(posedge sys_clk);
		rf_wr_en <= 1'b1;
		rf_wr_idx <= idx;
		rf_wr_data <= d;
		@(posedge sys_clk);
		rf_wr_en <= 1'b0;
	endtask

	task automatic rf_check(input logic [3:0] idx, input logic [31:0] exp);
		@(posedge sys_clk);
		rf_rd_idx <= idx;
		@(posedge sys_clk);
		#1;
		chk_data(rf_rd_data, exp, "register value");
	endtask

	task automatic issue(input sau_op_t op, input logic [3:0] d, input logic [3:0] sa, input logic [3:0] sb,
		input logic c, input logic [5:0] n, input logic arith_right_shift, input logic [4:0] sh, input logic ref_exp);
		int k;
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req_op <= op;
		req_dst <= d;
		req_src_a <= sa;
		req_src_b <= sb;
		req_cond <= c;
		req_n <= n;
		req_asr <= arith_right_shift;
		req_shamt <= sh;
		@(posedge sys_clk);
		req_valid <= 1'b0;
		#1;
		k = 0;
		while (!(req_done || req_refused) && k < 8) begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		chk_data({30'h0, req_done, req_refused}, {30'h0, !ref_exp, ref_exp}, "answer kind");
		chk_data(32'(k), (ref_exp || op >= OP_STATUS_WRITE) ? 32'h0 : 32'h2, "answer latency");
	endtask

	task automatic run(input sau_op_t op, input logic [31:0] a, input logic [31:0] b, input logic c = 1'b1,
		input logic [5:0] n = 6'h00, input logic arith_right_shift = 1'b0, input logic [4:0] sh = 5'h00);
		logic [31:0] exp;
		int ev0;
		rf_load(4'h1, a);
		rf_load(4'h2, b);
		rf_load(4'h3, MARK);
		exp = model(op, a, b, n, arith_right_shift, sh);
		ev0 = sat_count;
		issue(op, 4'h3, 4'h1, 4'h2, c, n, arith_right_shift, sh, 1'b0);
		if (!c)
			exp = MARK;
		else if (op <= OP_SAT_SUB_WORD)
			expq |= sat_hit;
		rf_check(4'h3, exp);
		chk_bit(q_status, expq, "sticky flag");
		chk_bit(sat_count != ev0, c && op <= OP_SAT_SUB_WORD && sat_hit, "saturation event");
	endtask

	task automatic status_write(input logic [31:0] v);
		rf_load(4'h4, v);
		issue(OP_STATUS_WRITE, 4'h0, 4'h0, 4'h4, 1'b1, 6'h00, 1'b0, 5'h00, 1'b0);
		if (!v[Q_BIT])
			expq = 1'b0;
	endtask

	task automatic status_read;
		issue(OP_STATUS_READ, 4'h5, 4'h0, 4'h0, 1'b1, 6'h00, 1'b0, 5'h00, 1'b0);
		rf_check(4'h5, {4'h0, expq, 27'h0});
	endtask

	initial begin
		sys_clk = 1'b0;
		rst = 1'b1;
		{req_valid, req_cond, req_asr, rf_wr_en, expq} = 5'h0;
		req_op = OP_SIGNED_CLAMP;
		{req_dst, req_src_a, req_src_b, rf_wr_idx, rf_rd_idx} = 20'h0;
		{req_n, req_shamt, rf_wr_data} = 43'h0;
		{fails, checks_done, cycles, sat_count} = 0;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk_bit(q_status, 1'b0, "flag after reset");
		chk_bit(req_ready, 1'b1, "ready after reset");
		run(OP_SAT_ADD_BYTES, 32'h7F80_017F, 32'h01FF_7F01);
		run(OP_SAT_SUB_BYTES, 32'h8000_7F10, 32'h0180_8020);
		run(OP_SAT_ADD_HALVES, 32'h7FFF_8000, 32'h0001_FFFF);
		run(OP_SAT_SUB_HALVES, 32'h8000_7FFF, 32'h0001_FFFF);
		run(OP_SAT_ADD_SUB_EXCHANGE, 32'h7FFF_8000, 32'h0001_0001);
		run(OP_SAT_SUB_ADD_EXCHANGE, 32'h8000_7FFF, 32'h0001_0001);
		$display("test lanes done");
		run(OP_SAT_ADD_WORD, 32'h7FFF_FFFF, 32'h0000_0001, 1'b0);
		run(OP_SAT_ADD_WORD, 32'h7FFF_FFFF, 32'h0000_0001);
		status_write(32'h0800_0000);
		status_read;
		status_write(32'h0000_0000);
		status_read;
		run(OP_SAT_SUB_WORD, 32'h8000_0000, 32'h0000_0001);
		run(OP_SAT_ADD_WORD, 32'h0000_0001, 32'h0000_0002);
		$display("test word and status done");
		status_write(32'h0);
		for (i = 1; i <= 32; i++) run(OP_SIGNED_CLAMP, 32'h0, 32'hFFFF_FF80, 1'b1, 6'(i));
		status_write(32'h0);
		for (i = 0; i <= 31; i++) run(OP_UNSIGNED_CLAMP, 32'h0, 32'h0000_00FF, 1'b1, 6'(i), 1'b0, 5'(i));
		status_write(32'h0);
		for (i = 1; i <= 16; i++) run(OP_DUAL_SIGNED_CLAMP, 32'h0, 32'h8000_00FF, 1'b1, 6'(i));
		status_write(32'h0);
		for (i = 0; i <= 15; i++) run(OP_DUAL_UNSIGNED_CLAMP, 32'h0, 32'h8000_7FFF, 1'b1, 6'(i));
		run(OP_SIGNED_CLAMP, 32'h0, 32'h8000_0000, 1'b1, 6'h20, 1'b1, 5'h1F);
		status_write(32'h0);
		run(OP_UNSIGNED_CLAMP, 32'h0, 32'hFFFF_FFFF, 1'b1, 6'h08, 1'b1, 5'h01);
		$display("test clamps done");
		issue(OP_SIGNED_CLAMP, 4'h3, 4'h1, 4'h2, 1'b1, 6'h00, 1'b0, 5'h00, 1'b1);
		issue(OP_SIGNED_CLAMP, 4'h3, 4'h1, 4'h2, 1'b1, 6'h21, 1'b0, 5'h00, 1'b1);
		issue(OP_UNSIGNED_CLAMP, 4'h3, 4'h1, 4'h2, 1'b1, 6'h20, 1'b0, 5'h00, 1'b1);
		issue(OP_DUAL_SIGNED_CLAMP, 4'h3, 4'h1, 4'h2, 1'b1, 6'h11, 1'b0, 5'h00, 1'b1);
		issue(OP_DUAL_UNSIGNED_CLAMP, 4'h3, 4'h1, 4'h2, 1'b1, 6'h10, 1'b0, 5'h00, 1'b1);
		issue(OP_SIGNED_CLAMP, 4'h3, 4'h1, 4'h2, 1'b1, 6'h08, 1'b1, 5'h00, 1'b1);
		issue(OP_SAT_ADD_WORD, 4'hD, 4'h1, 4'h2, 1'b1, 6'h00, 1'b0, 5'h00, 1'b1);
		issue(OP_SAT_ADD_WORD, 4'h3, 4'hF, 4'h2, 1'b1, 6'h00, 1'b0, 5'h00, 1'b1);
		issue(OP_SAT_SUB_WORD, 4'h3, 4'h1, 4'hD, 1'b1, 6'h00, 1'b0, 5'h00, 1'b1);
		rf_check(4'h3, 32'h0000_0000);
		$display("test refusals done");
		final_report;
	end
endmodule // saturating_arith_unit_tb
